// >>> rtl/dimg_pkg.sv
// Constants and types shared by the digital I/O multiplexer group
package dimg_pkg;
    localparam int CARD_W = 8;           // Signals served by one multiplexer card
    localparam int WORD_W = 24;          // Widest group word, three cards
    localparam int MAX_CARDS = 3;        // Cards in one group
    localparam int MAX_MUX_CARDS = 16;   // Multiplexer cards in one nest row
    localparam int NUM_LEVELS = 8;       // Interrupt levels shared by all groups
    localparam int LEVEL_W = 3;
    localparam int MAX_PINT_GROUPS = 16; // Process interrupt groups in the system
    localparam int MAX_PINT_INPUTS = 384;
    localparam int CLK_PERIOD_PS = 10000;        // 100 MHz system clock
    localparam int MOM_PULSE_US = 16500;         // Momentary output pulse, 16.5 ms
    // Scaled in two steps so the product stays inside a 32-bit int
    localparam int MOM_PULSE_CYC = MOM_PULSE_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;

    // Signal type that a group's cards carry
    typedef enum logic [2:0] {
        KIND_CONTACT,
        KIND_PINT,
        KIND_STEADY,
        KIND_MOMENT,
        KIND_RELAY
    } dimg_kind_e;

    // Commands from the device synchronizer
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_LEVEL
    } dimg_op_e;
endpackage

// >>> rtl/dimg_card_if.sv
// Link between the group control logic and one output multiplexer card
`timescale 1ns/1ps
interface dimg_card_if;
    import dimg_pkg::*;
    logic wr;
    logic [CARD_W-1:0] wdata;
    logic [CARD_W-1:0] level;

    modport ctrl (output wr, output wdata, input level);
    modport card (input wr, input wdata, output level);
endinterface

// >>> rtl/dimg_card.sv
// One output multiplexer card: 8-bit store, optional momentary pulse gate
`timescale 1ns/1ps
module dimg_card
    import dimg_pkg::*;
#(
    parameter dimg_kind_e KIND = KIND_STEADY,
    parameter int PULSE_CYC = MOM_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    dimg_card_if.card bus
);
    localparam int CNT_W = $clog2(PULSE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PULSE_CYC - 1);

    typedef struct packed {
        logic [CARD_W-1:0] store;
        logic active;
        logic [CNT_W-1:0] cnt;
    } dimg_card_s;

    dimg_card_s st;
    dimg_card_s next_st;

    // Store on every write; momentary cards restart the gate on each write
    always_comb begin
        next_st = st;
        if (bus.wr) begin
            next_st.store = bus.wdata;
        end
        if (KIND == KIND_MOMENT) begin
            if (bus.wr) begin
                next_st.active = 1'b1;
                next_st.cnt = CNT_LOAD;
            end else if (st.active) begin
                if (st.cnt == '0) begin
                    next_st.active = 1'b0;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Momentary lines only see ones while the gate runs; zeros never pulse
    assign bus.level = (KIND == KIND_MOMENT) ? (st.store & {CARD_W{st.active}}) : st.store;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    card_store_a: assert property (bus.wr |=> st.store == $past(bus.wdata))
        else $error("card did not latch its byte");
    pulse_start_a: assert property ((KIND == KIND_MOMENT) && bus.wr |=> st.active
        && bus.level == st.store)
        else $error("momentary pulse did not start on write");
    pulse_length_a: assert property ($fell(st.active) |-> $past(st.cnt) == '0)
        else $error("momentary pulse ended early");
    pulse_zero_a: assert property ((bus.level & ~st.store) == '0)
        else $error("output active on a zero bit");
    pulse_end_c: cover property ((KIND == KIND_MOMENT) && $fell(st.active));
endmodule // dimg_card

// >>> rtl/dimg_group.sv
// Digital I/O multiplexer group: contact, interrupt and dc output word access
`timescale 1ns/1ps
module dimg_group
    import dimg_pkg::*;
#(
    parameter dimg_kind_e KIND = KIND_PINT,
    parameter int NUM_CARDS = 3,
    parameter int MUX_CARDS = 3,
    parameter bit NEST_SPLIT = 1'b0,
    parameter bit TOP_IS_INPUT = 1'b1,
    parameter bit LOWER_IS_INPUT = 1'b1,
    parameter bit ON_TOP_ROW = 1'b1,
    parameter logic [LEVEL_W-1:0] IRQ_LEVEL = 3'h0,
    parameter int GROUP_ID = 0,
    parameter int PULSE_CYC = MOM_PULSE_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire dimg_op_e CMD_OP,
    input wire logic CMD_CRIT,
    input wire logic [LEVEL_W-1:0] CMD_LEVEL,
    input wire logic [WORD_W-1:0] CMD_WDATA,
    output logic CMD_RSP,
    output logic [WORD_W-1:0] CMD_RDATA,
    output logic [MAX_PINT_GROUPS-1:0] LVL_BITS,
    input wire logic [WORD_W-1:0] CONTACT,
    output logic IRQ_REQ,
    output logic GROUP_PEND,
    output logic [WORD_W-1:0] DOUT,
    output logic [WORD_W-1:0] RELAY_A,
    output logic [WORD_W-1:0] RELAY_B
);
    localparam bit IS_INPUT = (KIND == KIND_CONTACT) || (KIND == KIND_PINT);
    localparam bit IS_PINT = (KIND == KIND_PINT);
    // Direction of the row this group sits on; a whole nest uses the top setting
    localparam bit ROW_IS_INPUT = (NEST_SPLIT && !ON_TOP_ROW) ? LOWER_IS_INPUT : TOP_IS_INPUT;
    localparam logic [WORD_W-1:0] CARD_MASK = WORD_W'((32'h1 << (CARD_W * NUM_CARDS)) - 1);

    // Build-time checks on the configuration
    if (NUM_CARDS < 1 || NUM_CARDS > MAX_CARDS) begin : g_bad_cards
        $error("group must hold one to three cards");
    end
    if (!NEST_SPLIT && (TOP_IS_INPUT != LOWER_IS_INPUT)) begin : g_bad_nest
        $error("whole nest must use one direction");
    end
    if (ROW_IS_INPUT != IS_INPUT) begin : g_bad_row
        $error("group kind does not match row direction");
    end
    if (MUX_CARDS < 1 || MUX_CARDS > MAX_MUX_CARDS) begin : g_bad_mux
        $error("row must hold one to sixteen cards");
    end
    if (IS_PINT && (GROUP_ID < 0 || GROUP_ID >= MAX_PINT_GROUPS)) begin : g_bad_id
        $error("interrupt group number out of range");
    end

    typedef struct packed {
        logic rsp;
        logic [WORD_W-1:0] rdata;
        logic [MAX_PINT_GROUPS-1:0] lvl_bits;
        logic [WORD_W-1:0] cause;
        logic pend;
        logic irq;
    } dimg_group_s;

    dimg_group_s st;
    dimg_group_s next_st;
    logic [WORD_W-1:0] closed;
    wire logic [WORD_W-1:0] card_out;
    logic is_read;
    logic is_crit_read;
    logic is_own_level;
    logic is_write;

    // Closed contacts read as one; unpopulated card slices read as zero
    assign closed = IS_INPUT ? (CONTACT & CARD_MASK) : WORD_ZERO;
    assign is_read = CMD_VALID && (CMD_OP == OP_READ);
    assign is_crit_read = is_read && CMD_CRIT && IS_PINT;
    assign is_own_level = CMD_VALID && (CMD_OP == OP_LEVEL) && (CMD_LEVEL == IRQ_LEVEL);
    assign is_write = CMD_VALID && (CMD_OP == OP_WRITE) && !IS_INPUT;

    // Command answers and interrupt bookkeeping
    always_comb begin
        next_st = st;
        next_st.rsp = CMD_VALID;
        next_st.lvl_bits = '0;
        if (is_read) begin
            // Critical read on an interrupt group returns the causing contacts
            next_st.rdata = is_crit_read ? st.cause : closed;
        end else if (CMD_VALID) begin
            next_st.rdata = WORD_ZERO;
        end
        if (is_own_level && IS_PINT) begin
            next_st.lvl_bits[GROUP_ID] = st.pend;
        end
        if (IS_PINT) begin
            // A contact closing in the clearing cycle is kept, set wins
            next_st.cause = (is_crit_read ? WORD_ZERO : st.cause) | closed;
            next_st.irq = |closed;
            next_st.pend = (is_own_level ? 1'b0 : st.pend) | (|closed);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Output cards, one per byte of the group word
    for (genvar c = 0; c < MAX_CARDS; c++) begin : g_card
        if (c < NUM_CARDS && !IS_INPUT) begin : g_fit
            dimg_card_if cif ();
            assign cif.wr = is_write;
            assign cif.wdata = CMD_WDATA[c*CARD_W +: CARD_W];
            assign card_out[c*CARD_W +: CARD_W] = cif.level;
            dimg_card #(
                .KIND(KIND),
                .PULSE_CYC(PULSE_CYC)
            ) u_card (
                .clk(CLK_SYS),
                .rst(RST),
                .bus(cif)
            );
        end else begin : g_empty
            assign card_out[c*CARD_W +: CARD_W] = '0;
        end
    end

    assign CMD_RSP = st.rsp;
    assign CMD_RDATA = st.rdata;
    assign LVL_BITS = st.lvl_bits;
    assign IRQ_REQ = st.irq;
    assign GROUP_PEND = st.pend;
    // Relay pairs drive opposite coils; RELAY_B is the complement of RELAY_A on populated slices
    assign DOUT = (KIND == KIND_RELAY) ? WORD_ZERO : card_out;
    assign RELAY_A = (KIND == KIND_RELAY) ? card_out : WORD_ZERO;
    assign RELAY_B = (KIND == KIND_RELAY) ? (~card_out & CARD_MASK) : WORD_ZERO;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    cmd_answer_a: assert property (CMD_VALID |=> CMD_RSP ##1 !CMD_RSP || $past(CMD_VALID))
        else $error("command not answered next cycle");
    contact_read_a: assert property (is_read && !is_crit_read |=>
        CMD_RDATA == $past(closed))
        else $error("read word not the contact states");
    closed_one_a: assert property (is_read && !is_crit_read && IS_INPUT |=>
        CMD_RDATA == ($past(CONTACT) & CARD_MASK))
        else $error("closed contact not read as one");
    cause_read_a: assert property (is_crit_read |=> CMD_RDATA == $past(st.cause))
        else $error("critical read did not return cause word");
    cause_reset_a: assert property (is_crit_read |=> st.cause == $past(closed))
        else $error("critical read did not reset inputs");
    irq_or_a: assert property (IS_PINT && (closed != '0) |=> IRQ_REQ ##1
        (IRQ_REQ == $past(closed != '0)))
        else $error("interrupt request not OR of contacts");
    pend_hold_a: assert property (GROUP_PEND && !is_own_level |=> GROUP_PEND)
        else $error("group bit lost before interrogation");
    level_answer_a: assert property (IS_PINT && is_own_level && GROUP_PEND |=>
        LVL_BITS[GROUP_ID] && CMD_RSP)
        else $error("own level interrogation not answered");
    steady_out_a: assert property ((KIND == KIND_STEADY) && is_write |=>
        DOUT == ($past(CMD_WDATA) & CARD_MASK))
        else $error("steady outputs not updated at once");
    relay_pair_a: assert property ((KIND == KIND_RELAY) |->
        (RELAY_A ^ RELAY_B) == CARD_MASK)
        else $error("relay pair not complementary");

    crit_read_c: cover property (is_crit_read && st.cause != '0);
    level_hit_c: cover property (is_own_level && GROUP_PEND);
    write_c: cover property (is_write);
    set_clear_c: cover property (is_crit_read && closed != '0);
endmodule // dimg_group

// >>> tb/dimg_plant.sv
// Plant-side model: field contacts seen by the group
`timescale 1ns/1ps
module dimg_plant
    import dimg_pkg::*;
(
    input wire logic clk,
    input wire logic [WORD_W-1:0] want,
    output logic [WORD_W-1:0] contact
);
    // Contacts move just after the edge, like a synchronised field input
    initial contact = 24'h000000;
    always @(posedge clk) begin
        contact <= #1 want;
    end
endmodule // dimg_plant

// >>> tb/dimg_group_tb.sv
// Self-checking bench for the digital I/O multiplexer group
`timescale 1ns/1ps
module dimg_group_tb;
    import dimg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] valid = 4'h0;
    dimg_op_e op = OP_READ;
    logic crit = 1'b0;
    logic [LEVEL_W-1:0] lvl = 3'h0;
    logic [WORD_W-1:0] wdata = 24'h000000;
    logic [WORD_W-1:0] want = 24'h000000;
    logic [WORD_W-1:0] contact;
    wire logic [3:0] rsp;
    logic [WORD_W-1:0] rdata;
    logic [WORD_W-1:0] rdata_s;
    logic [MAX_PINT_GROUPS-1:0] lvl_bits;
    logic [MAX_PINT_GROUPS-1:0] lvl_seen = 16'h0000;
    logic [WORD_W-1:0] dout_s;
    // Short pulse count so the momentary test stays brief
    localparam int MOM_CYC = 20;
    logic irq;
    logic pend;
    logic [WORD_W-1:0] dout_m;
    logic [WORD_W-1:0] rel_a;
    logic [WORD_W-1:0] rel_b;
    int fails = 0;
    int checks_done = 0;

    // Free-running 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    dimg_plant dimg_plant_inst (.clk(clk_sys), .want(want), .contact(contact));

    // Four groups share the command lines; each has its own strobe
    dimg_group #(.KIND(KIND_PINT), .IRQ_LEVEL(3'h2), .GROUP_ID(5)) dimg_group_inst (
        .CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(valid[0]), .CMD_OP(op), .CMD_CRIT(crit),
        .CMD_LEVEL(lvl), .CMD_WDATA(wdata), .CMD_RSP(rsp[0]), .CMD_RDATA(rdata),
        .LVL_BITS(lvl_bits), .CONTACT(contact), .IRQ_REQ(irq), .GROUP_PEND(pend),
        .DOUT(), .RELAY_A(), .RELAY_B());
    dimg_group #(.KIND(KIND_MOMENT), .NUM_CARDS(2), .PULSE_CYC(MOM_CYC), .TOP_IS_INPUT(1'b0),
                 .LOWER_IS_INPUT(1'b0)) dimg_group_inst_m (
        .CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(valid[1]), .CMD_OP(op), .CMD_CRIT(crit),
        .CMD_LEVEL(lvl), .CMD_WDATA(wdata), .CMD_RSP(rsp[1]), .CMD_RDATA(),
        .LVL_BITS(), .CONTACT(contact), .IRQ_REQ(), .GROUP_PEND(),
        .DOUT(dout_m), .RELAY_A(), .RELAY_B());
    dimg_group #(.KIND(KIND_RELAY), .TOP_IS_INPUT(1'b0), .LOWER_IS_INPUT(1'b0))
    dimg_group_inst_r (
        .CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(valid[2]), .CMD_OP(op), .CMD_CRIT(crit),
        .CMD_LEVEL(lvl), .CMD_WDATA(wdata), .CMD_RSP(rsp[2]), .CMD_RDATA(),
        .LVL_BITS(), .CONTACT(contact), .IRQ_REQ(), .GROUP_PEND(),
        .DOUT(), .RELAY_A(rel_a), .RELAY_B(rel_b));
    dimg_group #(.KIND(KIND_STEADY), .NUM_CARDS(1), .TOP_IS_INPUT(1'b0),
                 .LOWER_IS_INPUT(1'b0)) dimg_group_inst_s (
        .CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(valid[3]), .CMD_OP(op), .CMD_CRIT(crit),
        .CMD_LEVEL(lvl), .CMD_WDATA(wdata), .CMD_RSP(rsp[3]), .CMD_RDATA(rdata_s),
        .LVL_BITS(), .CONTACT(contact), .IRQ_REQ(), .GROUP_PEND(),
        .DOUT(dout_s), .RELAY_A(), .RELAY_B());

    task automatic chk(input string what, input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle command strobe; answer and level bits stand only one cycle,
    // so they are taken just after the taken edge, then one idle edge follows
    task automatic cmd(input int g, input dimg_op_e o, input logic c,
                       input logic [WORD_W-1:0] d);
        valid[g] = 1'b1;
        op = o;
        crit = c;
        wdata = d;
        @(posedge clk_sys);
        #1;
        valid = 4'h0;
        crit = 1'b0;
        lvl_seen = lvl_bits;
        chk("answer strobe", {23'h0, rsp[g]}, 24'h000001);
        @(posedge clk_sys);
        #1;
        chk("answer dropped", {23'h0, rsp[g]}, 24'h000000);
    endtask

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask

    // Contact read, interrupt request, level interrogation, read and reset
    task automatic t_interrupt();
        want = 24'hA53C81;
        step();
        step();
        chk("irq request", {23'h0, irq}, 24'h000001);
        chk("group pending", {23'h0, pend}, 24'h000001);
        cmd(0, OP_READ, 1'b0, 24'h000000);
        chk("contact word", rdata, 24'hA53C81);
        want = 24'h000000;
        step();
        step();
        chk("irq after open", {23'h0, irq}, 24'h000000);
        chk("pending held", {23'h0, pend}, 24'h000001);
        lvl = 3'h3;
        cmd(0, OP_LEVEL, 1'b0, 24'h000000);
        chk("other level bits", {8'h00, lvl_seen}, 24'h000000);
        chk("pending kept", {23'h0, pend}, 24'h000001);
        lvl = 3'h2;
        cmd(0, OP_LEVEL, 1'b0, 24'h000000);
        chk("own level bits", {8'h00, lvl_seen}, 24'h000020);
        chk("level bits dropped", {8'h00, lvl_bits}, 24'h000000);
        chk("pending cleared", {23'h0, pend}, 24'h000000);
        cmd(0, OP_READ, 1'b1, 24'h000000);
        chk("cause word", rdata, 24'hA53C81);
        cmd(0, OP_READ, 1'b1, 24'h000000);
        chk("cause reset", rdata, 24'h000000);
        $display("interrupt test done");
    endtask

    // Two-card momentary group: pulse lasts exactly the set count
    task automatic t_moment();
        cmd(1, OP_WRITE, 1'b0, 24'hFFC35A);
        chk("pulse start", dout_m, 24'h00C35A);
        // The command returns one cycle into the pulse
        repeat (MOM_CYC - 2) step();
        chk("pulse last cycle", dout_m, 24'h00C35A);
        step();
        chk("pulse ended", dout_m, 24'h000000);
        $display("momentary test done");
    endtask

    // Relay driver: complementary pairs held until the next write
    task automatic t_relay();
        cmd(2, OP_WRITE, 1'b0, 24'h0FA530);
        repeat (5) step();
        chk("coil a", rel_a, 24'h0FA530);
        chk("coil b", rel_b, 24'hF05ACF);
        cmd(2, OP_WRITE, 1'b0, 24'h81FF00);
        chk("coil a new", rel_a, 24'h81FF00);
        chk("coil b new", rel_b, 24'h7E00FF);
        $display("relay test done");
    endtask

    // One-card steady group: low byte shows at once and holds; upper slices stay off
    task automatic t_steady();
        cmd(3, OP_WRITE, 1'b0, 24'h3C5AA7);
        chk("steady byte", dout_s, 24'h0000A7);
        cmd(3, OP_READ, 1'b0, 24'h000000);
        repeat (3) step();
        chk("steady held", dout_s, 24'h0000A7);
        chk("output group read", rdata_s, 24'h000000);
        $display("steady test done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Tests need about 60 cycles; twenty microseconds leaves ample margin
    initial begin
        #20000;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_interrupt();
        t_moment();
        t_relay();
        t_steady();
        wrap_up();
    end
endmodule // dimg_group_tb
